// *** lpdrp_ctrl.sv ***
// Command sequencer for refresh, power states and clock stop of a low-power DDR memory
`default_nettype none
`timescale 1ns/100ps

module lpdrp_ctrl
   import lpdrp_pkg::*;
#(
   parameter int DEEP_WAKE = lpdrp_pkg::DEEP_WAKE_SLOTS
) (
   input  wire logic                         mclk,
   input  wire logic                         rst,
   input  wire logic                         ce,
   input  wire logic [lpdrp_pkg::CNT_W-1:0]  cfg_trcd,
   input  wire logic [lpdrp_pkg::CNT_W-1:0]  cfg_trp,
   input  wire logic [lpdrp_pkg::CNT_W-1:0]  cfg_trfc,
   input  wire logic [lpdrp_pkg::CNT_W-1:0]  cfg_txsr,
   input  wire logic [lpdrp_pkg::CNT_W-1:0]  cfg_txp,
   input  wire logic [lpdrp_pkg::CNT_W-1:0]  cfg_tcke,
   input  wire logic [lpdrp_pkg::CNT_W-1:0]  cfg_tburst,
   input  wire logic                         req_valid,
   output logic                              req_ready,
   input  wire logic                         req_write,
   input  wire logic                         req_auto_pre,
   input  wire logic [lpdrp_pkg::BA_W-1:0]   req_bank,
   input  wire logic [lpdrp_pkg::ROW_W-1:0]  req_row,
   input  wire logic [lpdrp_pkg::COL_W-1:0]  req_col,
   input  wire logic                         sr_req,
   input  wire logic                         pd_req,
   input  wire logic                         deep_req,
   input  wire logic                         stop_req,
   input  wire logic                         reinit_done,
   output logic                              reinit_req,
   output logic                              in_self_refresh,
   output logic                              in_power_down,
   output logic                              in_deepest_sleep_state,
   output logic                              clock_stopped,
   output logic                              refresh_due,
   output logic                              ck,
   output logic                              ck_n,
   output logic                              cke,
   output logic                              cs_n,
   output logic                              ras_n,
   output logic                              cas_n,
   output logic                              we_n,
   output logic      [lpdrp_pkg::BA_W-1:0]   ba,
   output logic      [lpdrp_pkg::ADDR_W-1:0] addr
);

   import lpdrp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations
   lpdrp_state_t     state;
   logic             phase;
   logic             tick;
   logic             ck_run;
   logic [2:0]       cmd;
   logic             issue;
   logic             sr_first;
   logic             w_load;
   logic [CNT_W-1:0] w_val;
   logic [CNT_W-1:0] w_count;
   logic             w_done;
   logic [CNT_W-1:0] r_count;
   logic             r_done;
   logic             r_load;
   logic             ref_pending;
   logic             ref_clr;
   logic             ref_set;
   logic             bank_open [BANKS];
   logic [ROW_W-1:0] bank_row  [BANKS];
   logic             any_open;
   logic             hit;
   logic             urgent;

   assign tick   = ce & phase;
   assign r_load = tick & r_done;
   assign {ras_n, cas_n, we_n} = cmd;
   assign hit    = bank_open[req_bank] && (bank_row[req_bank] == req_row);
   assign urgent = ref_pending | sr_req | deep_req;
   assign req_ready = ce && phase && (state == st_idle) && w_done && !urgent && req_valid && hit;

   assign reinit_req             = (state == st_reinit);
   assign in_self_refresh        = (state == st_sr) || (state == st_sr_wake);
   assign in_power_down          = (state == st_pd);
   assign in_deepest_sleep_state = (state == st_deepest_sleep_state) || (state == st_deep_wake);
   assign clock_stopped          = ~ck_run;
   assign refresh_due            = ref_pending;

   always_comb begin
      any_open = 1'b0;
      for (int i = 0; i < BANKS; i++) begin
         any_open = any_open | bank_open[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Clock divider driving the memory clock pair
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         phase <= 1'b0;
         ck    <= 1'b0;
         ck_n  <= 1'b1;
      end else if (ce) begin
         phase <= ~phase;
         ck    <= ck_run & ~phase;
         ck_n  <= ~(ck_run & ~phase);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Timers
   lpdrp_timer u_wait (
      .mclk     (mclk),
      .rst      (rst),
      .ce       (ce),
      .tick     (tick),
      .load     (w_load),
      .load_val (w_val),
      .count    (w_count),
      .done     (w_done)
   );

   lpdrp_timer u_refi (
      .mclk     (mclk),
      .rst      (rst),
      .ce       (ce),
      .tick     (tick),
      .load     (r_load),
      .load_val (CNT_W'(REFI_SLOTS)),
      .count    (r_count),
      .done     (r_done)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Refresh owed; a new set wins over a clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ref_pending <= 1'b0;
      end else if (ce) begin
         if (r_load || ref_set) begin
            ref_pending <= 1'b1;
         end else if (ref_clr) begin
            ref_pending <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Open row table per bank, tracked from issued commands
   for (genvar b = 0; b < BANKS; b++) begin : g_bank
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            bank_open[b] <= 1'b0;
            bank_row[b]  <= '0;
         end else if (ce && issue && (cmd == CMD_ACT) && (ba == BA_W'(b))) begin
            bank_open[b] <= 1'b1;
            bank_row[b]  <= addr[ROW_W-1:0];
         end else if (ce && issue && (cmd == CMD_PRE) && (addr[AP_BIT] || (ba == BA_W'(b)))) begin
            bank_open[b] <= 1'b0;
         end else if (ce && issue && ((cmd == CMD_RD) || (cmd == CMD_WR)) && addr[AP_BIT]
                      && (ba == BA_W'(b))) begin
            bank_open[b] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer; commands change only on slot edges while the clock is low
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state    <= st_reinit;
         cke      <= 1'b0;
         cs_n     <= 1'b1;
         cmd      <= CMD_NOP;
         ba       <= '0;
         addr     <= '0;
         ck_run   <= 1'b1;
         issue    <= 1'b0;
         sr_first <= 1'b0;
         w_load   <= 1'b0;
         w_val    <= '0;
         ref_clr  <= 1'b0;
         ref_set  <= 1'b0;
      end else if (ce) begin
         issue   <= 1'b0;
         w_load  <= 1'b0;
         ref_clr <= 1'b0;
         ref_set <= 1'b0;
         if (phase) begin
            cmd <= CMD_NOP;
            unique case (state)
               st_reinit: begin
                  cke  <= 1'b1;
                  cs_n <= 1'b0;
                  if (reinit_done) begin
                     state <= st_idle;
                  end
               end
               st_idle: begin
                  if (w_done && urgent) begin
                     if (any_open) begin
                        cmd          <= CMD_PRE;
                        addr[AP_BIT] <= 1'b1;
                        issue        <= 1'b1;
                        w_load       <= 1'b1;
                        w_val        <= cfg_trp;
                     end else if (ref_pending) begin
                        cmd     <= CMD_REF;
                        issue   <= 1'b1;
                        ref_clr <= 1'b1;
                        w_load  <= 1'b1;
                        w_val   <= cfg_trfc;
                     end else if (deep_req) begin
                        cmd    <= CMD_BST;
                        cke    <= 1'b0;
                        issue  <= 1'b1;
                        w_load <= 1'b1;
                        w_val  <= CNT_W'(1);
                        state  <= st_deepest_sleep_state;
                     end else begin
                        cmd      <= CMD_REF;
                        cke      <= 1'b0;
                        issue    <= 1'b1;
                        sr_first <= 1'b1;
                        w_load   <= 1'b1;
                        w_val    <= cfg_trfc;
                        state    <= st_sr;
                     end
                  end else if (w_done && req_valid) begin
                     ba     <= req_bank;
                     issue  <= 1'b1;
                     w_load <= 1'b1;
                     if (hit) begin
                        cmd          <= req_write ? CMD_WR : CMD_RD;
                        addr         <= ADDR_W'(req_col);
                        addr[AP_BIT] <= req_auto_pre;
                        w_val        <= req_auto_pre ? CNT_W'(cfg_tburst + cfg_trp) : cfg_tburst;
                     end else if (bank_open[req_bank]) begin
                        cmd          <= CMD_PRE;
                        addr[AP_BIT] <= 1'b0;
                        w_val        <= cfg_trp;
                     end else begin
                        cmd   <= CMD_ACT;
                        addr  <= ADDR_W'(req_row);
                        w_val <= cfg_trcd;
                     end
                  end else if (w_done && pd_req) begin
                     cke    <= 1'b0;
                     w_load <= 1'b1;
                     w_val  <= cfg_tcke;
                     state  <= st_pd;
                  end else if (w_done && stop_req) begin
                     ck_run <= 1'b0;
                     state  <= st_cstop;
                  end
               end
               st_sr: begin
                  if (sr_first) begin
                     sr_first <= 1'b0;
                  end else if (!sr_req && w_done) begin
                     ck_run <= 1'b1;
                     w_load <= 1'b1;
                     w_val  <= CNT_W'(CLK_WAKE_SLOTS);
                     state  <= st_sr_wake;
                  end else begin
                     ck_run <= 1'b0;
                  end
               end
               st_sr_wake: begin
                  if (w_done) begin
                     cke     <= 1'b1;
                     w_load  <= 1'b1;
                     w_val   <= cfg_txsr;
                     ref_set <= 1'b1;
                     state   <= st_idle;
                  end
               end
               st_pd: begin
                  if ((!pd_req || ref_pending) && w_done) begin
                     cke    <= 1'b1;
                     w_load <= 1'b1;
                     w_val  <= cfg_txp;
                     state  <= st_idle;
                  end
               end
               st_deepest_sleep_state: begin
                  if (!deep_req && w_done) begin
                     cke    <= 1'b1;
                     w_load <= 1'b1;
                     w_val  <= CNT_W'(DEEP_WAKE);
                     state  <= st_deep_wake;
                  end
               end
               st_deep_wake: begin
                  if (w_done) begin
                     state <= st_reinit;
                  end
               end
               st_cstop: begin
                  if (!stop_req || req_valid || urgent || pd_req) begin
                     ck_run <= 1'b1;
                     state  <= st_cs_wake;
                  end
               end
               st_cs_wake: begin
                  state <= st_idle;
               end
               default: begin
                  state <= st_reinit;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions
   property p_ap_bit;
      @(posedge mclk) disable iff (rst)
      req_ready |=> ((cmd == CMD_RD) || (cmd == CMD_WR)) && (addr[AP_BIT] == $past(req_auto_pre));
   endproperty
   a_ap_bit: assert property (p_ap_bit) else $error("column command lost auto precharge choice");

   property p_ap_wait;
      @(posedge mclk) disable iff (rst)
      (issue && ((cmd == CMD_RD) || (cmd == CMD_WR)) && addr[AP_BIT])
         |=> (w_count == CNT_W'(cfg_tburst + cfg_trp));
   endproperty
   a_ap_wait: assert property (p_ap_wait) else $error("auto precharge wait not loaded");

   property p_cmd_gated;
      @(posedge mclk) disable iff (rst)
      (issue && (cmd != CMD_NOP)) |-> $past(w_done);
   endproperty
   a_cmd_gated: assert property (p_cmd_gated) else $error("command issued before wait expired");

   property p_refi;
      @(posedge mclk) disable iff (rst)
      r_load |=> ref_pending && (r_count == CNT_W'(REFI_SLOTS));
   endproperty
   a_refi: assert property (p_refi) else $error("refresh interval not restarted");

   property p_sr_clock;
      @(posedge mclk) disable iff (rst)
      (issue && (cmd == CMD_REF) && !cke) |-> ck_run [*4] ##1 (!ck_run || (state == st_sr_wake));
   endproperty
   a_sr_clock: assert property (p_sr_clock) else $error("clock stopped too early in self refresh");

   property p_sr_min;
      @(posedge mclk) disable iff (rst)
      ((state == st_sr) ##1 (state == st_sr_wake)) |-> $past(w_done) && !cke && ck_run;
   endproperty
   a_sr_min: assert property (p_sr_min) else $error("self refresh left too early");

   property p_sr_exit;
      @(posedge mclk) disable iff (rst)
      ($rose(cke) && ($past(state) == st_sr_wake)) |=> (w_count == cfg_txsr) && ref_pending;
   endproperty
   a_sr_exit: assert property (p_sr_exit) else $error("self refresh exit wait or extra refresh missing");

   property p_pd_exit;
      @(posedge mclk) disable iff (rst)
      ($rose(cke) && ($past(state) == st_pd)) |-> (cmd == CMD_NOP) ##1 (w_count == cfg_txp);
   endproperty
   a_pd_exit: assert property (p_pd_exit) else $error("power-down exit not a no-op with exit wait");

   property p_deep_entry;
      @(posedge mclk) disable iff (rst)
      (issue && (cmd == CMD_BST) && !cke) |-> !any_open ##1 (state == st_deepest_sleep_state);
   endproperty
   a_deep_entry: assert property (p_deep_entry) else $error("deep sleep entered with open bank");

   property p_deep_low;
      @(posedge mclk) disable iff (rst)
      (state == st_deepest_sleep_state) |-> !cke;
   endproperty
   a_deep_low: assert property (p_deep_low) else $error("enable rose during deep sleep");

   property p_deep_wake;
      @(posedge mclk) disable iff (rst)
      ($rose(cke) && ($past(state) == st_deepest_sleep_state)) |=> (w_count == CNT_W'(DEEP_WAKE));
   endproperty
   a_deep_wake: assert property (p_deep_wake) else $error("deep sleep exit wait not loaded");

   property p_clk_stop;
      @(posedge mclk) disable iff (rst)
      $fell(ck_run) |-> (cke && (state == st_cstop)) || (state == st_sr);
   endproperty
   a_clk_stop: assert property (p_clk_stop) else $error("clock stopped with enable low");

   property p_restart_nop;
      @(posedge mclk) disable iff (rst)
      ($rose(ck_run) && (state == st_cs_wake) && ce) |-> (cmd == CMD_NOP) [*4];
   endproperty
   a_restart_nop: assert property (p_restart_nop) else $error("access right after clock restart");

endmodule

`default_nettype wire

// *** lpdrp_pkg.sv ***
// Constants, command codes and states for the low-power DDR command sequencer
`default_nettype none

package lpdrp_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int ROW_W  = 14;
   localparam int COL_W  = 10;
   localparam int ADDR_W = 14;
   localparam int BA_W   = 2;
   localparam int BANKS  = 4;
   localparam int CNT_W  = 16;
   localparam int AP_BIT = 10;

   ////////////////////////////////////////////////////////////////////////////////
   // Command codes on {ras_n, cas_n, we_n} with chip select low
   localparam logic [2:0] CMD_NOP = 3'h7;
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_RD  = 3'h5;
   localparam logic [2:0] CMD_WR  = 3'h4;
   localparam logic [2:0] CMD_BST = 3'h6;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_REF = 3'h1;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing: memory clock is mclk divided by two, one command slot per period
   localparam int MCLK_NS        = 8;
   localparam int CK_DIV         = 2;
   localparam int SLOT_NS        = MCLK_NS * CK_DIV;
   localparam int REF_WINDOW_MS  = 64;
   localparam int REF_ROWS       = 8192;
   localparam int REFI_SLOTS     = (REF_WINDOW_MS * 1000000 / REF_ROWS) / SLOT_NS;
   localparam int DEEP_WAKE_US   = 200;
   localparam int DEEP_WAKE_SLOTS = (DEEP_WAKE_US * 1000 + SLOT_NS - 1) / SLOT_NS;
   localparam int CLK_WAKE_SLOTS = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer states
   typedef enum logic [3:0] {
      st_reinit    = 4'h0,
      st_idle      = 4'h1,
      st_sr        = 4'h2,
      st_sr_wake   = 4'h3,
      st_pd        = 4'h4,
      st_deepest_sleep_state = 4'h5,
      st_deep_wake = 4'h6,
      st_cstop     = 4'h7,
      st_cs_wake   = 4'h8
   } lpdrp_state_t;

endpackage

`default_nettype wire

// *** lpdrp_timer.sv ***
// Countdown timer in command slots
`default_nettype none
`timescale 1ns/100ps

module lpdrp_timer
   import lpdrp_pkg::*;
(
   input  wire logic                        mclk,
   input  wire logic                        rst,
   input  wire logic                        ce,
   input  wire logic                        tick,
   input  wire logic                        load,
   input  wire logic [lpdrp_pkg::CNT_W-1:0] load_val,
   output logic      [lpdrp_pkg::CNT_W-1:0] count,
   output logic                             done
);

   import lpdrp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Load wins over the decrement
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         count <= '0;
      end else if (ce) begin
         if (load) begin
            count <= load_val;
         end else if (tick && (count != '0)) begin
            count <= count - 1'b1;
         end
      end
   end

   assign done = (count == '0);

endmodule

`default_nettype wire

// *** lpdrp_mem_model.sv ***
// Behavioural low-power memory device answering the command sequencer
`default_nettype none
`timescale 1ns/100ps
module lpdrp_mem_model
   import lpdrp_pkg::*;
(
   input  wire logic                         ck,
   input  wire logic                         cke,
   input  wire logic                         cs_n,
   input  wire logic                         ras_n,
   input  wire logic                         cas_n,
   input  wire logic                         we_n,
   input  wire logic [lpdrp_pkg::BA_W-1:0]   ba,
   input  wire logic [lpdrp_pkg::ADDR_W-1:0] addr,
   output logic      [3:0]                   open_map,
   output logic      [3:0]                   last_col,
   output logic      [1:0]                   mode,
   output int                                ref_count,
   output int                                bad_count
);
   import lpdrp_pkg::*;
   logic [2:0] cmd;
   assign cmd = {ras_n, cas_n, we_n};
   initial begin
      open_map = '0;
      last_col = '0;
      mode = '0;
      ref_count = 0;
      bad_count = 0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Mode 0 run, 1 self refresh, 2 power-down, 3 deepest sleep
   always @(posedge ck) begin
      if (mode != 2'h0) begin
         if (cke) mode <= 2'h0;
         if (cke && mode == 2'h3) open_map <= '0;
      end else if (!cs_n && !cke) begin
         if (cmd == CMD_REF) mode <= 2'h1;
         else if (cmd == CMD_BST) mode <= 2'h3;
         else mode <= 2'h2;
         if (cmd != CMD_NOP && open_map != '0) bad_count <= bad_count + 1;
      end else if (!cs_n) begin
         case (cmd)
            CMD_ACT: begin
               if (open_map[ba]) bad_count <= bad_count + 1;
               open_map[ba] <= 1'b1;
            end
            CMD_RD, CMD_WR: begin
               if (!open_map[ba]) bad_count <= bad_count + 1;
               last_col <= {cmd == CMD_WR, addr[AP_BIT], ba};
               if (addr[AP_BIT]) open_map[ba] <= 1'b0;
            end
            CMD_PRE: if (addr[AP_BIT]) open_map <= '0; else open_map[ba] <= 1'b0;
            CMD_REF: begin
               if (open_map != '0) bad_count <= bad_count + 1;
               ref_count <= ref_count + 1;
            end
            default: ;
         endcase
      end
   end
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the command sequencer against the device model
`default_nettype none
`timescale 1ns/100ps
module testbench;
   import lpdrp_pkg::*;
   logic        mclk = 0, rst = 1, req_valid = 0, req_write = 0, req_auto_pre = 0;
   logic        sr_req = 0, pd_req = 0, deep_req = 0, stop_req = 0, reinit_done = 0;
   logic [15:0] cfg [7];
   logic [1:0]  req_bank = '0;
   logic [13:0] req_row = '0;
   logic [9:0]  req_col = '0;
   logic        req_ready, reinit_req, in_sr, in_pd, in_deep, stopped, ck, ck_n, cke;
   logic        cs_n, ras_n, cas_n, we_n, refresh_due;
   logic [1:0]  ba, mode;
   logic [13:0] addr;
   logic [3:0]  open_map, last_col;
   logic [6:0]  flags;
   logic [31:0] lfsr_state = 32'h5535;
   int          ref_count, bad_count, err_count = 0, num_checks = 0, i, n0;
   assign flags = {refresh_due, reinit_req, stopped, in_deep, in_pd, in_sr, req_ready};
   always #4 mclk = ~mclk;
   lpdrp_ctrl #(.DEEP_WAKE(4)) lpdrp_ctrl_i (.mclk(mclk), .rst(rst), .ce(1'b1),
      .cfg_trcd(cfg[0]), .cfg_trp(cfg[1]), .cfg_trfc(cfg[2]), .cfg_txsr(cfg[3]),
      .cfg_txp(cfg[4]), .cfg_tcke(cfg[5]), .cfg_tburst(cfg[6]), .req_valid(req_valid),
      .req_ready(req_ready), .req_write(req_write), .req_auto_pre(req_auto_pre),
      .req_bank(req_bank), .req_row(req_row), .req_col(req_col), .sr_req(sr_req),
      .pd_req(pd_req), .deep_req(deep_req), .stop_req(stop_req), .reinit_done(reinit_done),
      .reinit_req(reinit_req), .in_self_refresh(in_sr), .in_power_down(in_pd),
      .in_deepest_sleep_state(in_deep), .clock_stopped(stopped), .refresh_due(refresh_due),
      .ck(ck), .ck_n(ck_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
      .we_n(we_n), .ba(ba), .addr(addr));
   lpdrp_mem_model lpdrp_mem_model_i (.ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .open_map(open_map),
      .last_col(last_col), .mode(mode), .ref_count(ref_count), .bad_count(bad_count));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr_next();
      lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1]
         ^ lfsr_state[0]};
      return lfsr_state;
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_bit(input int idx, input logic val);
      int n;
      for (n = 0; n < 8000 && flags[idx] !== val; n++) @(posedge mclk);
      if (n == 8000) begin
         err_count++;
         $display("[FAIL] flag %0d expected %b seen timeout", idx, val);
         complete_run();
      end
   endtask
   task automatic access();
      logic [31:0] r;
      r = lfsr_next();
      req_bank <= r[1:0];
      req_auto_pre <= r[2];
      req_write <= r[3];
      req_row <= r[17:4];
      req_col <= r[27:18];
      req_valid <= 1'b1;
      wait_bit(0, 1'b1);
      req_valid <= 1'b0;
      repeat (5) @(posedge mclk);
      check("column command", last_col, {28'h0, r[3:0]});
      check("row left open", open_map[r[1:0]], !r[2]);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      for (i = 0; i < 7; i++) cfg[i] = 16'(lfsr_next() % 4 + 1);
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      wait_bit(5, 1'b1);
      reinit_done <= 1'b1;
      wait_bit(5, 1'b0);
      reinit_done <= 1'b0;
      repeat (30) @(posedge mclk);
      check("refresh after init", ref_count > 0, 1);
      for (i = 0; i < 8; i++) access();
      $display("test access done");
      sr_req <= 1'b1;
      wait_bit(1, 1'b1);
      repeat (20) @(posedge mclk);
      n0 = ref_count;
      check("self refresh mode", mode, 1);
      check("clock held", {ck, ck_n, cke}, 3'h2);
      sr_req <= 1'b0;
      wait_bit(1, 1'b0);
      wait_bit(6, 1'b1);
      wait_bit(6, 1'b0);
      repeat (40) @(posedge mclk);
      check("refresh after exit", ref_count > n0, 1);
      check("running after exit", mode, 0);
      $display("test self refresh done");
      pd_req <= 1'b1;
      wait_bit(2, 1'b1);
      repeat (6) @(posedge mclk);
      check("power-down mode", {mode, cke}, 3'h4);
      pd_req <= 1'b0;
      wait_bit(2, 1'b0);
      repeat (6) @(posedge mclk);
      check("power-down exit", mode, 0);
      access();
      $display("test power-down done");
      deep_req <= 1'b1;
      wait_bit(3, 1'b1);
      repeat (6) @(posedge mclk);
      check("deep sleep mode", {open_map, mode}, 6'h03);
      deep_req <= 1'b0;
      wait_bit(5, 1'b1);
      check("reinit after deep sleep", in_deep, 0);
      reinit_done <= 1'b1;
      wait_bit(5, 1'b0);
      reinit_done <= 1'b0;
      $display("test deep sleep done");
      stop_req <= 1'b1;
      wait_bit(4, 1'b1);
      repeat (4) @(posedge mclk);
      check("clock stop pins", {ck, ck_n, cke}, 3'h3);
      stop_req <= 1'b0;
      wait_bit(4, 1'b0);
      access();
      check("protocol faults", bad_count, 0);
      $display("test clock stop done");
      complete_run();
   end
endmodule
`default_nettype wire
